// ==== pkg/tbrid_defs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz pclk and byte-wide registers in 32-bit APB words
`ifndef TBRID_DEFS_SVH
`define TBRID_DEFS_SVH

`define TBRID_OFF_CONFIG 8'h00
`define TBRID_OFF_SETUP 8'h04
`define TBRID_OFF_STATION 8'h08
`define TBRID_OFF_PROBE 8'h0C
`define TBRID_OFF_MASK 8'h10
`define TBRID_OFF_DIAG 8'h14
`define TBRID_OFF_STATUS 8'h18
`define TBRID_OFF_SUCC 8'h1C
`define TBRID_OFF_CMD 8'h20
`define TBRID_OFF_APTR 8'h24

`define TBRID_CFG_SWRST 7
`define TBRID_CFG_JOIN 5
`define TBRID_SET_SHORT 0
`define TBRID_SET_SPAN_A 1
`define TBRID_SET_SPAN_B 2

`define TBRID_DG_SELF 7
`define TBRID_DG_CLASH 6
`define TBRID_DG_ACT 5
`define TBRID_DG_TOKEN 4
`define TBRID_DG_REFUSE 3
`define TBRID_DG_NEWSUCC 2
`define TBRID_DG_PROBE 1

`define TBRID_ST_REBUILD 2
`define TBRID_ST_REFUSE 1
`define TBRID_ST_TXIDLE 0

`define TBRID_CMD_DIS_TX 8'h01
`define TBRID_CMD_EN_TX 8'h02
`define TBRID_CMD_CLR_FLAGS 8'h03

`define TBRID_RST_BYTE 8'h00
`define TBRID_RAM_PATTERN 8'hD1
`define TBRID_RAM_ADDR0 11'h000
`define TBRID_RAM_ADDR1 11'h001

`define TBRID_REFUSE_LONG_LAST 7'h7F
`define TBRID_REFUSE_SHORT_LAST 7'h03

`define TBRID_CLK_NS 25
`define TBRID_RST_MIN_NS 3200
`define TBRID_RST_CYC \
   ((`TBRID_RST_MIN_NS + `TBRID_CLK_NS - 1) / `TBRID_CLK_NS)

`endif

// ==== pkg/tbrid_pkg.sv ====
// types shared by the reset, start-up and diagnostic block
// assumes nothing beyond the defs header
`default_nettype none
package tbrid_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_W0 = 2'b01,
      SEQ_W1 = 2'b11
   } tbrid_seq_t;

   // events from the token engine, one-cycle pulses on pclk
   typedef struct packed {
      logic tok_valid;
      logic tok_own;
      logic [7:0] tok_dest;
      logic reply;
      logic nak;
      logic timer_expired;
      logic rebuild;
      logic succ_valid;
      logic [7:0] succ_id;
   } tbrid_net_t;

   typedef struct packed {
      logic we;
      logic [10:0] addr;
      logic [7:0] data;
   } tbrid_ram_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic [7:0] cnt;
      logic hold;
   } tbrid_flt_st_t;

   typedef struct packed {
      logic [7:0] config_r;
      logic [7:0] setup_r;
      logic [7:0] station_r;
      logic [7:0] probe_r;
      logic [7:0] mask_r;
      logic [7:0] aptr_r;
      logic [7:0] succ_r;
      logic [7:0] last_dest_r;
      logic last_own_r;
      logic [7:0] rdata_r;
      logic [6:0] refuse_cnt_r;
      tbrid_seq_t seq_r;
      logic rx_s1_r;
      logic rx_s2_r;
      logic self_r;
      logic clash_r;
      logic act_r;
      logic token_r;
      logic refuse_r;
      logic newsucc_r;
      logic probe_hit_r;
      logic probe_arm_r;
      logic rebuild_r;
      logic txidle_r;
      logic txpend_r;
      logic abandon_r;
   } tbrid_st_t;

endpackage
`default_nettype wire

// ==== src/tbrid_core.sv ====
// reset, wake-up and diagnostic logic of the token bus network core
// assumes an APB master on pclk and a token engine on the same clock
//
// Behaviour
// - config bit 7 set holds the core in software reset
// - software reset keeps pointer, config, mask and setup registers
// - external reset is active high, filtered, needs 3.2 us
// - any reset disables transmitter; external reset also restores register defaults
// - zero station number: no microcode, tokens or rebuilds
// - station write stores D1 at RAM 0, station at RAM 1
// - joining waits for join enable, config bit 5
// - reply to token for own number sets clash flag in time
// - reading diagnostic status clears clash, self rebuild and new successor flags
// - own token timer expiry starting rebuild sets self rebuild flag
// - any rebuild sets network rebuild flag and interrupts
// - a one on the receive line sets line activity flag
// - foreign tokens set token seen flag, own tokens do not
// - reply to token for probe number sets probe match flag
// - new successor flag plus readable current successor register
// - 128 refusals, or 4, set refusal limit flag and interrupt
// - after disable, transmit idle sets at next token for own station number
// - refusal counter wraps; flag sets again after clear flags
//
// Our own choices: the address map and the APB interface to the registers.
`include "tbrid_defs.svh"
`default_nettype none
module tbrid_core
   import tbrid_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_reset,
   input wire logic rx_line_input,
   input wire tbrid_net_t net,
   output tbrid_ram_t ram,
   output logic core_reset,
   output logic core_run,
   output logic join_allow,
   output logic tx_enable,
   output logic irq
);

   localparam tbrid_st_t RST = '{
      txidle_r: 1'b1,
      seq_r: SEQ_IDLE,
      default: '0
   };

   tbrid_st_t s_r;
   tbrid_st_t s_nxt;
   logic hw_reset;
   logic sw_reset;
   logic setup_ph;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic run;
   logic joined;
   logic [6:0] refuse_last;
   logic [7:0] diag;
   logic [7:0] status;
   logic [7:0] rd_mux;

   tbrid_rst_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_reset),
      .hold(hw_reset)
   );

   assign sw_reset = s_r.config_r[`TBRID_CFG_SWRST];
   assign run = !sw_reset && !hw_reset && (s_r.station_r != 8'h00);
   assign joined = run && s_r.config_r[`TBRID_CFG_JOIN];
   assign refuse_last = s_r.setup_r[`TBRID_SET_SHORT]
      ? `TBRID_REFUSE_SHORT_LAST : `TBRID_REFUSE_LONG_LAST;

   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite && mapped;
   assign rd_acc = psel && penable && !pwrite && mapped;

   always_comb begin
      diag = 8'h00;
      diag[`TBRID_DG_SELF] = s_r.self_r;
      diag[`TBRID_DG_CLASH] = s_r.clash_r;
      diag[`TBRID_DG_ACT] = s_r.act_r;
      diag[`TBRID_DG_TOKEN] = s_r.token_r;
      diag[`TBRID_DG_REFUSE] = s_r.refuse_r;
      diag[`TBRID_DG_NEWSUCC] = s_r.newsucc_r;
      diag[`TBRID_DG_PROBE] = s_r.probe_hit_r;
      status = 8'h00;
      status[`TBRID_ST_REBUILD] = s_r.rebuild_r;
      status[`TBRID_ST_REFUSE] = s_r.refuse_r;
      status[`TBRID_ST_TXIDLE] = s_r.txidle_r;
   end

   always_comb begin
      mapped = 1'b1;
      rd_mux = 8'h00;
      unique case (paddr)
         `TBRID_OFF_CONFIG: rd_mux = s_r.config_r;
         `TBRID_OFF_SETUP: rd_mux = s_r.setup_r;
         `TBRID_OFF_STATION: rd_mux = s_r.station_r;
         `TBRID_OFF_PROBE: rd_mux = s_r.probe_r;
         `TBRID_OFF_MASK: rd_mux = s_r.mask_r;
         `TBRID_OFF_DIAG: rd_mux = diag;
         `TBRID_OFF_STATUS: rd_mux = status;
         `TBRID_OFF_SUCC: rd_mux = s_r.succ_r;
         `TBRID_OFF_CMD: rd_mux = 8'h00;
         `TBRID_OFF_APTR: rd_mux = s_r.aptr_r;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      if (sw_reset) begin
         s_nxt = RST;
         s_nxt.config_r = s_r.config_r;
         s_nxt.setup_r = s_r.setup_r;
         s_nxt.mask_r = s_r.mask_r;
         s_nxt.aptr_r = s_r.aptr_r;
         s_nxt.rdata_r = s_r.rdata_r;
      end
      s_nxt.rx_s1_r = rx_line_input;
      s_nxt.rx_s2_r = s_r.rx_s1_r;

      unique case (s_r.seq_r)
         SEQ_IDLE: s_nxt.seq_r = SEQ_IDLE;
         SEQ_W0: s_nxt.seq_r = SEQ_W1;
         SEQ_W1: s_nxt.seq_r = SEQ_IDLE;
         default: s_nxt.seq_r = SEQ_IDLE;
      endcase

      if (setup_ph) begin
         s_nxt.rdata_r = rd_mux;
      end

      if (rd_acc && paddr == `TBRID_OFF_DIAG) begin
         if (s_r.rdata_r[`TBRID_DG_CLASH]) begin
            s_nxt.clash_r = 1'b0;
         end
         if (s_r.rdata_r[`TBRID_DG_SELF]) begin
            s_nxt.self_r = 1'b0;
         end
         if (s_r.rdata_r[`TBRID_DG_NEWSUCC]) begin
            s_nxt.newsucc_r = 1'b0;
         end
      end

      if (wr_acc) begin
         unique case (paddr)
            `TBRID_OFF_CONFIG: s_nxt.config_r = pwdata[7:0];
            `TBRID_OFF_SETUP: s_nxt.setup_r = pwdata[7:0];
            `TBRID_OFF_STATION: begin
               s_nxt.station_r = pwdata[7:0];
               s_nxt.seq_r = SEQ_W0;
            end
            `TBRID_OFF_PROBE: begin
               s_nxt.probe_r = pwdata[7:0];
               s_nxt.probe_arm_r = 1'b1;
               s_nxt.probe_hit_r = 1'b0;
            end
            `TBRID_OFF_MASK: s_nxt.mask_r = pwdata[7:0];
            `TBRID_OFF_APTR: s_nxt.aptr_r = pwdata[7:0];
            `TBRID_OFF_CMD: begin
               unique case (pwdata[7:0])
                  `TBRID_CMD_DIS_TX: begin
                     s_nxt.txpend_r = 1'b0;
                     s_nxt.abandon_r = 1'b1;
                  end
                  `TBRID_CMD_EN_TX: begin
                     s_nxt.txpend_r = 1'b1;
                     s_nxt.txidle_r = 1'b0;
                     s_nxt.abandon_r = 1'b0;
                  end
                  `TBRID_CMD_CLR_FLAGS: begin
                     s_nxt.refuse_r = 1'b0;
                     s_nxt.rebuild_r = 1'b0;
                  end
                  default: s_nxt.abandon_r = s_nxt.abandon_r;
               endcase
            end
            default: s_nxt.aptr_r = s_nxt.aptr_r;
         endcase
      end

      if (s_r.rx_s2_r && !sw_reset) begin
         s_nxt.act_r = 1'b1;
      end

      if (run) begin
         if (net.tok_valid) begin
            s_nxt.last_dest_r = net.tok_dest;
            s_nxt.last_own_r = net.tok_own;
            if (!net.tok_own) begin
               s_nxt.token_r = 1'b1;
            end
            if (net.tok_dest == s_r.station_r && s_r.abandon_r) begin
               s_nxt.txidle_r = 1'b1;
               s_nxt.abandon_r = 1'b0;
            end
         end
         if (net.reply && !s_r.last_own_r) begin
            if (s_r.last_dest_r == s_r.station_r) begin
               s_nxt.clash_r = 1'b1;
            end
            if (s_r.probe_arm_r && s_r.last_dest_r == s_r.probe_r) begin
               s_nxt.probe_hit_r = 1'b1;
            end
         end
         if (net.nak) begin
            if (s_r.refuse_cnt_r >= refuse_last) begin
               s_nxt.refuse_cnt_r = 7'h00;
               s_nxt.refuse_r = 1'b1;
            end else begin
               s_nxt.refuse_cnt_r = s_r.refuse_cnt_r + 7'h01;
            end
         end
         if (net.succ_valid && net.succ_id != s_r.succ_r) begin
            s_nxt.succ_r = net.succ_id;
            s_nxt.newsucc_r = 1'b1;
         end
         if (net.rebuild) begin
            s_nxt.rebuild_r = 1'b1;
         end
      end

      if (joined && net.timer_expired) begin
         s_nxt.self_r = 1'b1;
         s_nxt.rebuild_r = 1'b1;
      end

      if (hw_reset) begin
         s_nxt = RST;
         s_nxt.rx_s1_r = rx_line_input;
         s_nxt.rx_s2_r = s_r.rx_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = {24'h000000, s_r.rdata_r};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      ram.we = (s_r.seq_r != SEQ_IDLE) && !sw_reset && !hw_reset;
      ram.addr = `TBRID_RAM_ADDR0;
      ram.data = `TBRID_RAM_PATTERN;
      if (s_r.seq_r == SEQ_W1) begin
         ram.addr = `TBRID_RAM_ADDR1;
         ram.data = s_r.station_r;
      end
   end

   assign core_reset = sw_reset || hw_reset;
   assign core_run = run;
   assign join_allow = joined;
   assign tx_enable = s_r.txpend_r && joined;
   assign irq = |(status & s_r.mask_r);

endmodule
`default_nettype wire

// ==== src/tbrid_rst_filter.sv ====
// glitch filter for the active-high external reset pin
// assumes the pin is asynchronous to pclk
`include "tbrid_defs.svh"
`default_nettype none
module tbrid_rst_filter
   import tbrid_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic hold
);

   localparam logic [7:0] LAST = 8'(`TBRID_RST_CYC - 1);

   tbrid_flt_st_t s_r;
   tbrid_flt_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pin;
      s_nxt.s2 = s_r.s1;
      if (!s_r.s2) begin
         s_nxt.cnt = 8'h00;
         s_nxt.hold = 1'b0;
      end else if (s_r.cnt == LAST) begin
         s_nxt.hold = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hold = s_r.hold;

endmodule
`default_nettype wire

// ==== test/tb_token_bus_reset_init_diag.sv ====
// self-checking bench for the reset, start-up and diagnostic core
// assumes the peer model and the bound port checker
`include "tbrid_defs.svh"
`default_nettype none
module tb_token_bus_reset_init_diag
   import tbrid_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, er, ext_reset;
   logic rx_line_input, core_reset, core_run, join_allow;
   logic tx_enable, irq, pready, pslverr;
   logic [7:0] paddr, st, p, su;
   logic [31:0] pwdata, prdata, r;
   tbrid_net_t net;
   tbrid_ram_t ram;
   int errors, comparisons, cyc, i, lim;
   int seed = 32'hAE4D;
   tbrid_core DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ext_reset, .rx_line_input, .net, .ram,
      .core_reset, .core_run, .join_allow, .tx_enable, .irq
   );
   tbrid_net_model nm (.pclk, .net);
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task cb(input logic s, input logic e);
      chk({31'h0, s}, {31'h0, e});
   endtask
   task xf(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e);
      xf(1'b0, a, 8'h00);
      chk(r, {24'h000000, e});
   endtask
   task tend(input int n);
      $display("test %0d done", n);
   endtask
   task test_done;
      $display("counts: %0d errors %0d comparisons", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ext_reset, rx_line_input} = 2'b00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rc(`TBRID_OFF_STATUS, 8'h01);
      xf(1'b0, 8'h30, 8'h00);
      cb(er, 1'b1);
      chk(r, 32'h0);
      nm.ev(0, 8'h12);
      rc(`TBRID_OFF_DIAG, 8'h00);
      tend(1);
      st = 8'($random(seed)) | 8'h01;
      xf(1'b1, `TBRID_OFF_SETUP, 8'h01);
      xf(1'b1, `TBRID_OFF_STATION, st);
      cb(core_run, 1'b1);
      cb(join_allow, 1'b0);
      xf(1'b1, `TBRID_OFF_CONFIG, 8'h20);
      cb(join_allow, 1'b1);
      nm.ev(1, 8'h33);
      rc(`TBRID_OFF_DIAG, 8'h00);
      @(posedge pclk);
      rx_line_input <= 1'b1;
      nm.ev(0, 8'h44);
      rx_line_input <= 1'b0;
      repeat (4) @(posedge pclk);
      rc(`TBRID_OFF_DIAG, 8'h30);
      tend(2);
      nm.ev(0, st);
      nm.ev(2, 8'h00);
      rc(`TBRID_OFF_DIAG, 8'h70);
      rc(`TBRID_OFF_DIAG, 8'h30);
      nm.ev(1, st);
      nm.ev(2, 8'h00);
      rc(`TBRID_OFF_DIAG, 8'h30);
      xf(1'b1, `TBRID_OFF_PROBE, st ^ 8'h80);
      nm.ev(0, st ^ 8'h80);
      nm.ev(2, 8'h00);
      su = 8'($random(seed)) | 8'h02;
      nm.ev(6, su);
      rc(`TBRID_OFF_DIAG, 8'h36);
      rc(`TBRID_OFF_SUCC, su);
      tend(3);
      xf(1'b1, `TBRID_OFF_MASK, 8'h06);
      nm.ev(4, 8'h00);
      nm.ev(5, 8'h00);
      rc(`TBRID_OFF_DIAG, 8'hB2);
      rc(`TBRID_OFF_STATUS, 8'h05);
      cb(irq, 1'b1);
      xf(1'b1, `TBRID_OFF_CMD, `TBRID_CMD_CLR_FLAGS);
      cb(irq, 1'b0);
      tend(4);
      for (i = 0; i < 2; i++) begin
         lim = (i == 0) ? 4 : 128;
         p = {5'h00, 2'($random(seed)), i == 0};
         xf(1'b1, `TBRID_OFF_SETUP, p);
         repeat (2) begin
            repeat (lim - 1) nm.ev(3, 8'h00);
            rc(`TBRID_OFF_STATUS, 8'h01);
            nm.ev(3, 8'h00);
            rc(`TBRID_OFF_STATUS, 8'h03);
            cb(irq, 1'b1);
            xf(1'b1, `TBRID_OFF_CMD, `TBRID_CMD_CLR_FLAGS);
         end
      end
      tend(5);
      xf(1'b1, `TBRID_OFF_CMD, `TBRID_CMD_EN_TX);
      cb(tx_enable, 1'b1);
      xf(1'b1, `TBRID_OFF_CMD, `TBRID_CMD_DIS_TX);
      rc(`TBRID_OFF_STATUS, 8'h00);
      nm.ev(0, st);
      rc(`TBRID_OFF_STATUS, 8'h01);
      tend(6);
      xf(1'b1, `TBRID_OFF_APTR, 8'h5A);
      xf(1'b1, `TBRID_OFF_CONFIG, 8'hA0);
      rc(`TBRID_OFF_CONFIG, 8'hA0);
      rc(`TBRID_OFF_SETUP, p);
      rc(`TBRID_OFF_MASK, 8'h06);
      rc(`TBRID_OFF_APTR, 8'h5A);
      rc(`TBRID_OFF_STATION, 8'h00);
      cb(core_reset, 1'b1);
      xf(1'b1, `TBRID_OFF_CONFIG, 8'h20);
      cb(core_reset, 1'b0);
      tend(7);
      @(posedge pclk);
      ext_reset <= 1'b1;
      repeat (100) @(posedge pclk);
      ext_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      cb(core_reset, 1'b0);
      ext_reset <= 1'b1;
      repeat (150) @(posedge pclk);
      cb(core_reset, 1'b1);
      ext_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      rc(`TBRID_OFF_MASK, 8'h00);
      rc(`TBRID_OFF_CONFIG, 8'h00);
      tend(8);
      test_done();
   end
endmodule
`default_nettype wire

// ==== test/tbrid_core_properties.sv ====
// port checks for the reset, start-up and diagnostic core
// assumes a bind to tbrid_core on a single pclk domain
`include "tbrid_defs.svh"
`default_nettype none
module tbrid_core_props
   import tbrid_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic ext_reset,
   input wire tbrid_ram_t ram,
   input wire logic core_reset,
   input wire logic core_run,
   input wire logic join_allow,
   input wire logic tx_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] hi_cnt;
   logic wr;
   assign wr = psel && penable && pwrite;
   // run length of the raw reset pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hi_cnt <= 8'h00;
      else if (!ext_reset)
         hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF)
         hi_cnt <= hi_cnt + 8'h01;
   end
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_swrst_enter: assert property (
      wr && paddr == `TBRID_OFF_CONFIG && pwdata[`TBRID_CFG_SWRST]
      |=> core_reset) else $error("software reset not entered");
   a_ram_init: assert property (
      wr && paddr == `TBRID_OFF_STATION && !core_reset |=> ram.we
      && ram.addr == `TBRID_RAM_ADDR0 && ram.data == `TBRID_RAM_PATTERN
      ##1 ram.we && ram.addr == `TBRID_RAM_ADDR1
      && ram.data == $past(pwdata[7:0], 2) ##1 !ram.we)
      else $error("buffer start-up writes wrong");
   a_join_gate: assert property (
      join_allow |-> core_run && !core_reset)
      else $error("join allowed while asleep");
   a_tx_gate: assert property (
      tx_enable |-> join_allow) else $error("transmit before join");
   a_reset_quiet: assert property (
      core_reset |-> !core_run && !tx_enable)
      else $error("core active in reset");
   a_glitch_reject: assert property (
      $rose(core_reset) |-> hi_cnt == 8'h00 || hi_cnt >= 8'h80)
      else $error("short reset pulse accepted");
   a_reset_taken: assert property (
      hi_cnt >= 8'h8C |-> core_reset) else $error("long reset pin missed");
   a_err_phase: assert property (
      pslverr |-> psel && penable) else $error("error outside access");
   c_ram: cover property (ram.we);
   c_hw: cover property (hi_cnt == 8'h8C);
   c_join: cover property ($rose(join_allow));
endmodule
bind tbrid_core tbrid_core_props u_props (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .ext_reset, .ram, .core_reset, .core_run, .join_allow, .tx_enable
);
`default_nettype wire

// ==== test/tbrid_net_model.sv ====
// peer nodes on the token bus, seen as one-cycle event pulses
// assumes pclk is the core clock
`default_nettype none
module tbrid_net_model
   import tbrid_pkg::*;
(
   input wire logic pclk,
   output var tbrid_net_t net
);
   timeunit 1ns;
   timeprecision 100ps;
   initial net = '0;
   // k: 0 token 1 own token 2 reply 3 refusal 4 timer 5 rebuild 6 succ
   task ev(input int k, input logic [7:0] d);
      tbrid_net_t e;
      e = '0;
      e.tok_dest = d;
      e.succ_id = d;
      e.tok_valid = k < 2;
      e.tok_own = k == 1;
      e.reply = k == 2;
      e.nak = k == 3;
      e.timer_expired = k == 4;
      e.rebuild = k == 5;
      e.succ_valid = k == 6;
      @(posedge pclk);
      net <= e;
      @(posedge pclk);
      // stale ids flipped once the pulse is gone
      e = '0;
      e.tok_dest = ~d;
      e.succ_id = ~d;
      net <= e;
   endtask
endmodule
`default_nettype wire
